// [fpsi_front_panel.sv]
`include "fpsi_params.svh"

// Behaviour
// - Blinks toggle at one hertz, even duty
// - Amber lit forces green off
// - Status colour and blink per system condition
// - ACPI: S0 on, S1-S3 blink, S4/S5 off
// - Legacy: power indicator follows system power, blinks if sleep field not S0
// - Sleep state retained until firmware clears or rst_i resets it
// - Disk flashes on access, dark when off or in S1, S4 or S5
// - Disk activity merges onboard and header inputs
// - Locator blinks on button or remote request
// - Locator press toggles front and rear
// - Power press toggles power or requests sleep
// - Reset press reboots the system
// - NMI press halts and raises NMI
// - Critical thresholds, ECC, fatal bus errors are critical
// - Power control fault is critical
// - Bad processor installation is critical
// - Listed minor events show non-critical
// - Disabled parts or lost redundancy: degraded
// - Front monitor present routes video front
module fpsi_front_panel (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [31:0]            wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic                   wb_we_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire fpsi_pkg::fpsi_buttons_t btn_n_i,
  input  wire logic                   sys_power_on_i,
  input  wire logic                   pwr_off_req_i,
  input  wire logic                   post_active_i,
  input  wire logic [1:0]             disk_act_onboard_i,
  input  wire logic                   disk_act_header_i,
  input  wire logic                   front_monitor_i,
  output fpsi_pkg::fpsi_leds_t         leds_o,
  output fpsi_pkg::fpsi_reqs_t         reqs_o,
  output logic                        video_front_en_o,
  output logic                        video_rear_en_o
);

  localparam int BLINK_HALF = `FPSI_BLINK_HALF_CYC;
  localparam int DEB_CYC    = `FPSI_DEBOUNCE_CYC;
  localparam int PULSE_CYC  = `FPSI_PULSE_CYC;
  localparam int ACT_CYC    = `FPSI_ACT_STRETCH_CYC;

  function automatic logic sel_hit(input logic [31:0] adr, input logic [31:0] off);
    sel_hit = (adr[7:2] == off[7:2]) && (adr[31:8] == 24'h000000);
  endfunction : sel_hit

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge_bytes = r;
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  logic [31:0] ctrl_q;
  logic [31:0] event_q;
  logic        wb_req;
  logic        wr_ctrl;
  logic        wr_event;
  logic        hit_ctrl;
  logic        hit_event;
  logic        hit_status;
  logic        fault_q;
  logic        slp_clr;
  logic        locator_q;
  logic        locator_rear_q;

  // Address decode shared by reads and writes
  always_comb begin
    hit_ctrl   = 1'b0;
    hit_event  = 1'b0;
    hit_status = 1'b0;
    if (sel_hit(wb_adr_i, `FPSI_REG_CTRL)) begin
      hit_ctrl = 1'b1;
    end else if (sel_hit(wb_adr_i, `FPSI_REG_EVENT)) begin
      hit_event = 1'b1;
    end else if (sel_hit(wb_adr_i, `FPSI_REG_STATUS)) begin
      hit_status = 1'b1;
    end
  end

  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl  = wb_req && wb_we_i && hit_ctrl;
  assign wr_event = wb_req && wb_we_i && hit_event;
  assign slp_clr  = wr_ctrl && wb_sel_i[0] && wb_dat_i[`FPSI_CTRL_SLP_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      if (hit_ctrl) begin
        wb_dat_o <= {24'h000000, 1'b0, ctrl_q[6:0]};
      end else if (hit_event) begin
        wb_dat_o <= event_q;
      end else if (hit_status) begin
        wb_dat_o <= {24'h000000, fault_q, locator_rear_q, locator_q, front_monitor_i,
                     post_active_i, sys_power_on_i, leds_o.status_amber, leds_o.status_green};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // Sleep field survives system power loss; cleared only by firmware or rst_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `FPSI_CTRL_RESET;
    end else if (slp_clr) begin
      ctrl_q <= merge_bytes(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_000F;
    end else if (wr_ctrl) begin
      ctrl_q <= merge_bytes(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_007F;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_q <= `FPSI_EV_RESET;
    end else if (wr_event) begin
      event_q <= merge_bytes(event_q, wb_dat_i, wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared blink divider
  logic [23:0] blink_cnt_q;
  logic        blink_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_q <= 24'h000000;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == 24'(BLINK_HALF - 1)) begin
      blink_cnt_q <= 24'h000000;
      blink_q     <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Button synchronise and debounce
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [3:0]  stable_q;
  logic [3:0]  press;
  logic [19:0] deb_cnt_q [4];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end else begin
      sync1_q <= btn_n_i;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stable_q <= 4'hF;
      for (int i = 0; i < 4; i++) begin
        deb_cnt_q[i] <= 20'h00000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (sync2_q[i] == stable_q[i]) begin
          deb_cnt_q[i] <= 20'h00000;
        end else if (deb_cnt_q[i] == 20'(DEB_CYC - 1)) begin
          deb_cnt_q[i] <= 20'h00000;
          stable_q[i]  <= sync2_q[i];
        end else begin
          deb_cnt_q[i] <= deb_cnt_q[i] + 20'h00001;
        end
      end
    end
  end

  // One press per falling edge of the debounced level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      press[i] = stable_q[i] && (deb_cnt_q[i] == 20'(DEB_CYC - 1)) && !sync2_q[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Button requests as stretched pulses
  logic [15:0] pulse_cnt_q;
  fpsi_pkg::fpsi_reqs_t req_hold_q;
  logic        acpi_sleep_en;

  assign acpi_sleep_en = ctrl_q[`FPSI_CTRL_ACPI_BIT] && ctrl_q[`FPSI_CTRL_SLEEP_EN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_hold_q  <= '0;
      pulse_cnt_q <= 16'h0000;
    end else if (|press[3:2] || press[1] || press[0]) begin
      req_hold_q.power_toggle <= press[3] && !acpi_sleep_en;
      req_hold_q.sleep_req    <= press[3] && acpi_sleep_en;
      req_hold_q.sys_reset    <= press[1];
      req_hold_q.nmi          <= press[0];
      pulse_cnt_q             <= 16'(PULSE_CYC - 1);
    end else if (pulse_cnt_q != 16'h0000) begin
      pulse_cnt_q <= pulse_cnt_q - 16'h0001;
    end else begin
      req_hold_q <= '0;
    end
  end

  assign reqs_o = req_hold_q;

  ////////////////////////////////////////////////////////////////////////////
  // Locator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locator_q <= 1'b0;
    end else if (press[2]) begin
      locator_q <= ~locator_q;
    end
  end

  // Rear indicator keeps its own state, toggled by the same press
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locator_rear_q <= 1'b0;
    end else if (press[2]) begin
      locator_rear_q <= ~locator_rear_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status condition
  logic crit;
  logic noncrit;
  logic degraded;
  logic off_req_q;

  // Power-off request one cycle late, to spot power left on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_req_q <= 1'b0;
    end else begin
      off_req_q <= pwr_off_req_i;
    end
  end

  // Power stays on after power-off request is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else if (pwr_off_req_i) begin
      fault_q <= 1'b0;
    end else if (off_req_q && sys_power_on_i) begin
      fault_q <= 1'b1;
    end
  end

  assign crit = event_q[`FPSI_EV_CRIT_THR] || event_q[`FPSI_EV_ECC] ||
                event_q[`FPSI_EV_BUS_FATAL] || event_q[`FPSI_EV_BP_FAULT] ||
                event_q[`FPSI_EV_CPU_BAD] || event_q[`FPSI_EV_SAT_CRIT] || fault_q;
  assign noncrit = event_q[`FPSI_EV_NC_THR] || event_q[`FPSI_EV_INTRUSION] ||
                   event_q[`FPSI_EV_SAT_NC] || event_q[`FPSI_EV_FW_CFG];
  assign degraded = event_q[`FPSI_EV_CPU_DIS] || event_q[`FPSI_EV_MEM_DIS] ||
                    (event_q[`FPSI_EV_PSU_NONRED] && ctrl_q[`FPSI_CTRL_REDUND]);

  ////////////////////////////////////////////////////////////////////////////
  // Disk activity stretch
  logic [19:0] act_cnt_q;
  logic        disk_any;
  fpsi_pkg::fpsi_sleep_t slp;

  assign slp      = fpsi_pkg::fpsi_sleep_t'(ctrl_q[`FPSI_CTRL_SLP_MSB:`FPSI_CTRL_SLP_LSB]);
  assign disk_any = |disk_act_onboard_i || disk_act_header_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_cnt_q <= 20'h00000;
    end else if (disk_any) begin
      act_cnt_q <= 20'(ACT_CYC - 1);
    end else if (act_cnt_q != 20'h00000) begin
      act_cnt_q <= act_cnt_q - 20'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator outputs
  logic pwr_led;
  logic amber;
  logic green;
  logic disk_dark;

  always_comb begin
    pwr_led = 1'b0;
    if (ctrl_q[`FPSI_CTRL_ACPI_BIT]) begin
      case (slp)
        fpsi_pkg::FPSI_ACPI_S0: pwr_led = sys_power_on_i;
        fpsi_pkg::FPSI_ACPI_S1,
        fpsi_pkg::FPSI_ACPI_S2,
        fpsi_pkg::FPSI_ACPI_S3: pwr_led = blink_q;
        default:                pwr_led = 1'b0;
      endcase
    end else if (slp != fpsi_pkg::FPSI_ACPI_S0 && sys_power_on_i) begin
      pwr_led = blink_q;
    end else begin
      pwr_led = sys_power_on_i;
    end
  end

  always_comb begin
    amber = 1'b0;
    green = 1'b0;
    if (!sys_power_on_i || post_active_i) begin
      amber = 1'b0;
    end else if (crit) begin
      amber = 1'b1;
    end else if (noncrit) begin
      amber = blink_q;
    end else if (degraded) begin
      green = blink_q;
    end else begin
      green = 1'b1;
    end
  end

  assign disk_dark = !sys_power_on_i || (slp == fpsi_pkg::FPSI_ACPI_S1) ||
                     (slp == fpsi_pkg::FPSI_ACPI_S4) || (slp == fpsi_pkg::FPSI_ACPI_S5);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      leds_o <= '0;
    end else begin
      leds_o.power_green   <= pwr_led;
      leds_o.status_amber  <= amber;
      leds_o.status_green  <= green && !amber && !(crit || noncrit);
      leds_o.disk_act      <= (act_cnt_q != 20'h00000) && blink_cnt_q[`FPSI_ACT_CHOP_BIT] && !disk_dark;
      leds_o.locator_front <= (locator_q || ctrl_q[`FPSI_CTRL_LOC_REQ]) && blink_q;
      leds_o.locator_rear  <= (locator_rear_q || ctrl_q[`FPSI_CTRL_LOC_REQ]) && blink_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Video routing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      video_front_en_o <= 1'b0;
      video_rear_en_o  <= 1'b1;
    end else begin
      video_front_en_o <= front_monitor_i;
      video_rear_en_o  <= !front_monitor_i;
    end
  end

endmodule : fpsi_front_panel

// [fpsi_front_panel_chk_sva.sv]
module fpsi_front_panel_chk (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire logic                 sys_power_on_i,
  input wire logic                 pwr_off_req_i,
  input wire logic                 post_active_i,
  input wire logic                 front_monitor_i,
  input wire fpsi_pkg::fpsi_leds_t leds_o,
  input wire fpsi_pkg::fpsi_reqs_t reqs_o,
  input wire logic                 video_front_en_o,
  input wire logic                 video_rear_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_unasked_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  amber_wins_a: assert property (leds_o.status_amber |-> !leds_o.status_green)
    else $error("green lit with amber");
  video_one_a: assert property (video_front_en_o != video_rear_en_o)
    else $error("video enables not exclusive");
  video_front_a: assert property (front_monitor_i [*5] |-> video_front_en_o)
    else $error("front video not chosen");
  video_rear_a: assert property (!front_monitor_i [*5] |-> video_rear_en_o)
    else $error("rear video not chosen");
  post_dark_a: assert property (post_active_i [*5] |-> !leds_o.status_green && !leds_o.status_amber)
    else $error("status lit during self test");
  power_fault_a: assert property ($fell(pwr_off_req_i) && sys_power_on_i ##1 sys_power_on_i && !post_active_i
    |-> ##[1:4] leds_o.status_amber)
    else $error("power fault not critical");
  reset_pulse_a: assert property ($rose(reqs_o.sys_reset) |=> reqs_o.sys_reset [*8])
    else $error("reset request too short");
  nmi_pulse_a: assert property ($rose(reqs_o.nmi) |=> reqs_o.nmi [*8])
    else $error("nmi request too short");
endmodule : fpsi_front_panel_chk

bind fpsi_front_panel fpsi_front_panel_chk fpsi_front_panel_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .sys_power_on_i, .pwr_off_req_i, .post_active_i, .front_monitor_i, .leds_o, .reqs_o,
  .video_front_en_o, .video_rear_en_o);

// [fpsi_front_panel_tb.sv]
module fpsi_front_panel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [31:0]             wb_adr_i, wb_dat_i, wb_dat_o, rd;
  logic [3:0]              wb_sel_i, lane;
  logic [1:0]              disk_act_onboard_i;
  logic                    sys_power_on_i, pwr_off_req_i, post_active_i, disk_act_header_i;
  logic                    front_monitor_i, video_front_en_o, video_rear_en_o;
  fpsi_pkg::fpsi_buttons_t btn_n_i;
  fpsi_pkg::fpsi_leds_t    leds_o;
  fpsi_pkg::fpsi_reqs_t    reqs_o;
  int                      bad_count, n_tests;

  fpsi_front_panel fpsi_front_panel_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .btn_n_i, .sys_power_on_i, .pwr_off_req_i, .post_active_i,
    .disk_act_onboard_i, .disk_act_header_i, .front_monitor_i, .leds_o, .reqs_o, .video_front_en_o,
    .video_rear_en_o);
  fpsi_mgmt_model fpsi_mgmt_model_i (.clk_i, .btn_n_o(btn_n_i), .sys_power_on_o(sys_power_on_i),
    .pwr_off_req_o(pwr_off_req_i), .post_active_o(post_active_i), .disk_act_onboard_o(disk_act_onboard_i),
    .disk_act_header_o(disk_act_header_i), .front_monitor_o(front_monitor_i));

  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task bchk(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask : bchk

  task wb(input logic [31:0] a, input logic w, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= lane;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'h1);
    chk("wb_ack_wait", 32'h2, t);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask : wb

  task rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    wb(a, 1'h0, 32'h0);
    chk(nm, exp, rd);
  endtask : rchk

  task settle;
    repeat (8) @(posedge clk_i);
  endtask : settle

  task do_reset;
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask : do_reset

  task flash(input string nm);
    int t;
    t = 0;
    while (leds_o.disk_act !== 1'h1 && t < 10000) begin
      @(posedge clk_i);
      t++;
    end
    bchk(nm, 1'h1, leds_o.disk_act);
  endtask : flash

  task dark(input int n);
    repeat (n) begin
      @(posedge clk_i);
      bchk("disk_act", 1'h0, leds_o.disk_act);
    end
  endtask : dark
  ////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end

  initial begin
    rst_i = 1'h1;
    {wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    lane = 4'hF;
    bad_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    rchk("ctrl", 32'h0, 32'h0);
    rchk("event", 32'h4, 32'h0);
    wb(32'h10, 1'h1, 32'hFFFFFFFF);
    rchk("unmapped", 32'h10, 32'h0);
    fpsi_mgmt_model_i.power(1'h1);
    dark(100);
    fpsi_mgmt_model_i.set_io(1'h0, 2'h0, 1'h1, 1'h0);
    flash("disk_header");
    do_reset();
    fpsi_mgmt_model_i.set_io(1'h0, 2'h1, 1'h0, 1'h0);
    flash("disk_onboard");
    do_reset();
    fpsi_mgmt_model_i.power(1'h0);
    dark(300);
    wb(32'h0, 1'h1, 32'h11);
    fpsi_mgmt_model_i.power(1'h1);
    dark(300);
    fpsi_mgmt_model_i.set_io(1'h0, 2'h0, 1'h0, 1'h0);
    for (int s = 0; s < 6; s++) begin
      wb(32'h0, 1'h1, 32'h1 | (s << 4));
      settle();
      if (s == 0 || s > 3) bchk("power_acpi", s == 0, leds_o.power_green);
    end
    wb(32'h0, 1'h1, 32'h0);
    settle();
    bchk("power_legacy", 1'h1, leds_o.power_green);
    fpsi_mgmt_model_i.power(1'h0);
    settle();
    bchk("power_legacy", 1'h0, leds_o.power_green);
    wb(32'h0, 1'h1, 32'h30);
    fpsi_mgmt_model_i.power(1'h1);
    fpsi_mgmt_model_i.power(1'h0);
    fpsi_mgmt_model_i.power(1'h1);
    rchk("ctrl_kept", 32'h0, 32'h30);
    wb(32'h0, 1'h1, 32'h80);
    rchk("ctrl_clear", 32'h0, 32'h0);
    settle();
    bchk("green_run", 1'h1, leds_o.status_green);
    bchk("amber_run", 1'h0, leds_o.status_amber);
    for (int b = 0; b < 19; b++) begin
      if (b < 6 || (b > 7 && b < 12) || b > 15) begin
        wb(32'h4, 1'h1, 32'h1 << b);
        settle();
        if (b < 12) bchk("status_green", 1'h0, leds_o.status_green);
        if (b < 6) bchk("status_amber", 1'h1, leds_o.status_amber);
        if (b > 15) bchk("status_amber", 1'h0, leds_o.status_amber);
        if (b == 18) bchk("status_green", 1'h1, leds_o.status_green);
        wb(32'h8, 1'h0, 32'h0);
        if (b < 6) chk("status_reg", 32'h2, rd & 32'h3);
      end
    end
    wb(32'h4, 1'h1, 32'h0);
    lane = 4'h2;
    wb(32'h4, 1'h1, 32'hFFFFFFFF);
    lane = 4'hF;
    rchk("event_lane", 32'h4, 32'h0000FF00);
    wb(32'h4, 1'h1, 32'h0);
    fpsi_mgmt_model_i.set_io(1'h1, 2'h0, 1'h0, 1'h0);
    settle();
    bchk("post_green", 1'h0, leds_o.status_green);
    fpsi_mgmt_model_i.set_io(1'h0, 2'h0, 1'h0, 1'h1);
    settle();
    bchk("video_front", 1'h1, video_front_en_o);
    bchk("video_rear", 1'h0, video_rear_en_o);
    fpsi_mgmt_model_i.set_io(1'h0, 2'h0, 1'h0, 1'h0);
    settle();
    bchk("video_rear", 1'h1, video_rear_en_o);
    fpsi_mgmt_model_i.off_request(1'h1);
    settle();
    bchk("fault_amber", 1'h1, leds_o.status_amber);
    rchk("status_fault", 32'h8, 32'h00000086);
    bchk("locator_front", 1'h0, leds_o.locator_front);
    for (int k = 0; k < 4; k++) begin
      fpsi_mgmt_model_i.glitch(k);
    end
    settle();
    chk("reqs_glitch", 32'h0, {28'h0, reqs_o});
    rchk("locator_glitch", 32'h8, 32'h00000086);
    fpsi_mgmt_model_i.off_request(1'h0);
    fpsi_mgmt_model_i.power(1'h1);
    settle();
    bchk("fault_clear", 1'h0, leds_o.status_amber);
    bchk("fault_green", 1'h1, leds_o.status_green);
    complete_run();
  end
endmodule : fpsi_front_panel_tb

// [fpsi_mgmt_model.sv]
module fpsi_mgmt_model (
  input  wire logic               clk_i,
  output fpsi_pkg::fpsi_buttons_t btn_n_o,
  output logic                    sys_power_on_o,
  output logic                    pwr_off_req_o,
  output logic                    post_active_o,
  output logic [1:0]              disk_act_onboard_o,
  output logic                    disk_act_header_o,
  output logic                    front_monitor_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Buttons only glitch: a real press outlasts the run
  initial begin
    btn_n_o = '1;
    sys_power_on_o = 1'h0;
    pwr_off_req_o = 1'h0;
    post_active_o = 1'h0;
    disk_act_onboard_o = 2'h0;
    disk_act_header_o = 1'h0;
    front_monitor_o = 1'h0;
  end
  ////////////////////////////////////////
  task power(input logic on);
    @(posedge clk_i);
    sys_power_on_o <= on;
  endtask : power

  task set_io(input logic post, input logic [1:0] onb, input logic hdr, input logic mon);
    @(posedge clk_i);
    post_active_o <= post;
    disk_act_onboard_o <= onb;
    disk_act_header_o <= hdr;
    front_monitor_o <= mon;
  endtask : set_io

  // Power drops while request is high, unless hang keeps it on
  task off_request(input logic hang);
    @(posedge clk_i);
    pwr_off_req_o <= 1'h1;
    repeat (4) @(posedge clk_i);
    if (!hang) sys_power_on_o <= 1'h0;
    @(posedge clk_i);
    pwr_off_req_o <= 1'h0;
  endtask : off_request

  // Short bounce on one button, far below the debounce span
  task glitch(input int idx);
    @(posedge clk_i);
    btn_n_o <= ~(4'h1 << idx);
    repeat (3) @(posedge clk_i);
    btn_n_o <= '1;
  endtask : glitch
endmodule : fpsi_mgmt_model

// [fpsi_params.svh]
`ifndef FPSI_PARAMS_SVH
`define FPSI_PARAMS_SVH

// Clock and timing
`define FPSI_CLK_HZ          25000000
`define FPSI_BLINK_HZ        1
`define FPSI_BLINK_HALF_CYC  (`FPSI_CLK_HZ / (2 * `FPSI_BLINK_HZ))
`define FPSI_DEBOUNCE_MS     20
`define FPSI_DEBOUNCE_CYC    ((`FPSI_CLK_HZ / 1000) * `FPSI_DEBOUNCE_MS)
`define FPSI_PULSE_MS        1
`define FPSI_PULSE_CYC       ((`FPSI_CLK_HZ / 1000) * `FPSI_PULSE_MS)
`define FPSI_ACT_STRETCH_MS  30
`define FPSI_ACT_STRETCH_CYC ((`FPSI_CLK_HZ / 1000) * `FPSI_ACT_STRETCH_MS)
`define FPSI_ACT_CHOP_BIT    12

// Register byte offsets
`define FPSI_REG_CTRL        32'h0000_0000
`define FPSI_REG_EVENT       32'h0000_0004
`define FPSI_REG_STATUS      32'h0000_0008

// Control register fields
`define FPSI_CTRL_ACPI_BIT   0
`define FPSI_CTRL_SLEEP_EN   1
`define FPSI_CTRL_LOC_REQ    2
`define FPSI_CTRL_REDUND     3
`define FPSI_CTRL_SLP_LSB    4
`define FPSI_CTRL_SLP_MSB    6
`define FPSI_CTRL_SLP_CLR    7
`define FPSI_CTRL_RESET      32'h0000_0000

// Event register fields
`define FPSI_EV_CRIT_THR     0
`define FPSI_EV_ECC          1
`define FPSI_EV_BUS_FATAL    2
`define FPSI_EV_BP_FAULT     3
`define FPSI_EV_CPU_BAD      4
`define FPSI_EV_SAT_CRIT     5
`define FPSI_EV_NC_THR       8
`define FPSI_EV_INTRUSION    9
`define FPSI_EV_SAT_NC       10
`define FPSI_EV_FW_CFG       11
`define FPSI_EV_CPU_DIS      16
`define FPSI_EV_MEM_DIS      17
`define FPSI_EV_PSU_NONRED   18
`define FPSI_EV_RESET        32'h0000_0000

`endif

// [fpsi_pkg.sv]
package fpsi_pkg;

  typedef enum logic [2:0] {
    FPSI_ACPI_S0,
    FPSI_ACPI_S1,
    FPSI_ACPI_S2,
    FPSI_ACPI_S3,
    FPSI_ACPI_S4,
    FPSI_ACPI_S5
  } fpsi_sleep_t;

  typedef enum logic [1:0] {
    FPSI_ST_OFF,
    FPSI_ST_GREEN,
    FPSI_ST_AMBER
  } fpsi_color_t;

  typedef struct packed {
    logic power;
    logic locator;
    logic reset;
    logic nmi;
  } fpsi_buttons_t;

  typedef struct packed {
    logic power_green;
    logic status_green;
    logic status_amber;
    logic disk_act;
    logic locator_front;
    logic locator_rear;
  } fpsi_leds_t;

  typedef struct packed {
    logic power_toggle;
    logic sleep_req;
    logic sys_reset;
    logic nmi;
  } fpsi_reqs_t;

endpackage : fpsi_pkg
